//--- logic/return_and_rotate_left_exec.v
// Executes the subroutine return and rotate-left-through-carry opcodes.
// Assumes one AHB-Lite master on hclk issuing single word transfers.
// Assumes hready comes back from hreadyout, since this is the only slave.

`include "rlx_regs.vh"

module return_and_rotate_left_exec (
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave port.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata
);

    // ----------------------------------------
    // Bus states
    // ----------------------------------------
    localparam [2:0] st_ready = 3'b001;
    localparam [2:0] st_access = 3'b010;
    localparam [2:0] st_idle_cycle = 3'b100;

    reg [2:0] state;
    reg acc_write;
    reg [7:0] acc_addr;

    // ----------------------------------------
    // Core state
    // ----------------------------------------
    reg ext_enable;
    reg [7:0] working;
    reg [7:0] flags;
    reg [3:0] bank_select_register;
    reg [7:0] working_shadow;
    reg [7:0] flags_shadow;
    reg [3:0] bank_select_shadow;
    reg [20:0] pc;
    reg [3:0] sp;
    reg [11:0] index_base;
    reg [11:0] mem_addr;
    reg bad_opcode;
    reg stack_fault;
    reg [20:0] return_stack [0:7];
    reg [7:0] file_mem [0:4095];

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire addr_taken;
    wire do_write;
    wire exec;
    wire ret_op;
    wire ret_restore;
    wire rot_op;
    wire rot_d;
    wire rot_a;
    wire [7:0] rot_f;
    wire indexed;
    wire [3:0] sp_m1;
    wire [20:0] top_of_stack;
    reg [11:0] rot_addr;
    wire [7:0] rot_val;
    wire [7:0] rotate_left_through_carry;
    wire stack_full;
    reg [7:0] next_flags;
    reg [31:0] next_rdata;

    // Only NONSEQ and SEQ transfers start an access.
    assign addr_taken = hsel && hready && htrans[1];
    assign do_write = (state == st_access) && acc_write;
    // Writing the instruction register runs the opcode in that same data phase.
    assign exec = do_write && (acc_addr == `OFS_INSTR);

    // Bit 0 of a return is s, so the match covers bits 15:1 only.
    assign ret_op = (hwdata[15:1] == `OP_RETURN);
    assign ret_restore = hwdata[0];
    assign rot_op = (hwdata[15:10] == `OP_ROTATE);
    assign rot_d = hwdata[9];
    assign rot_a = hwdata[8];
    assign rot_f = hwdata[7:0];

    assign sp_m1 = sp - 4'h1;
    assign stack_full = (sp == `STACK_DEPTH);
    // An empty stack reads as zero rather than as stale contents.
    assign top_of_stack = (sp == 4'h0) ? `RST_PC : return_stack[sp_m1[2:0]];

    // Indexed addressing only stands in for the low part of the access bank.
    assign indexed = ext_enable && !rot_a && (rot_f <= `ACCESS_LIMIT);

    // The access bank splits at the same boundary as the indexed window.
    always @* begin
        if (indexed) begin
            rot_addr = index_base + {4'h0, rot_f};
        end else if (rot_a) begin
            rot_addr = {bank_select_register, rot_f};
        end else if (rot_f <= `ACCESS_LIMIT) begin
            rot_addr = {4'h0, rot_f};
        end else begin
            rot_addr = {`ACCESS_HIGH_BANK, rot_f};
        end
    end

    assign rot_val = file_mem[rot_addr];
    assign rotate_left_through_carry = {rot_val[6:0], flags[`FLAG_CARRY]};

    // ----------------------------------------
    // Rotate flag update
    // ----------------------------------------
    // Only carry, negative and zero move; the other flag bits keep their value.
    always @* begin
        next_flags = flags;
        next_flags[`FLAG_CARRY] = rot_val[7];
        next_flags[`FLAG_NEG] = rotate_left_through_carry[7];
        next_flags[`FLAG_ZERO] = (rotate_left_through_carry == 8'h00);
    end

    // ----------------------------------------
    // Bus sequencing
    // ----------------------------------------
    // Every access takes one wait state, and a return two, so reads see all earlier writes.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_ready;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            acc_write <= 1'b0;
            acc_addr <= `RST_BYTE;
        end else begin
            // Every transfer completes with an OKAY response.
            hresp <= 1'b0;
            case (state)
                st_ready: begin
                    if (addr_taken) begin
                        state <= st_access;
                        hreadyout <= 1'b0;
                        acc_write <= hwrite;
                        acc_addr <= {haddr[7:2], 2'b00};
                    end
                end
                st_access: begin
                    // Holding hreadyout low here keeps the next address phase off the bus.
                    if (exec && ret_op) begin
                        state <= st_idle_cycle;
                    end else begin
                        state <= st_ready;
                        hreadyout <= 1'b1;
                    end
                end
                st_idle_cycle: begin
                    // This wait state stands for the idle second cycle of a return.
                    state <= st_ready;
                    hreadyout <= 1'b1;
                end
                default: begin
                    state <= st_ready;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Read data is loaded at the end of the wait state and holds until the next read.
    always @* begin
        next_rdata = 32'h0000_0000;
        case (acc_addr)
            `OFS_CTRL: next_rdata = {31'h0000_0000, ext_enable};
            // Status packs the depth in the low nibble and the two faults above it.
            `OFS_STATUS: next_rdata = {22'h00_0000, stack_fault, bad_opcode, 4'h0, sp};
            `OFS_WORKING: next_rdata = {24'h00_0000, working};
            `OFS_FLAGS: next_rdata = {24'h00_0000, flags};
            `OFS_BANK: next_rdata = {28'h000_0000, bank_select_register};
            `OFS_WORKING_SH: next_rdata = {24'h00_0000, working_shadow};
            `OFS_FLAGS_SH: next_rdata = {24'h00_0000, flags_shadow};
            `OFS_BANK_SH: next_rdata = {28'h000_0000, bank_select_shadow};
            `OFS_PC: next_rdata = {11'h000, pc};
            `OFS_STACK: next_rdata = {11'h000, top_of_stack};
            `OFS_INDEX: next_rdata = {20'h0_0000, index_base};
            `OFS_MEM_ADDR: next_rdata = {20'h0_0000, mem_addr};
            `OFS_MEM_DATA: next_rdata = {24'h00_0000, file_mem[mem_addr]};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if ((state == st_access) && !acc_write) begin
            hrdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Register writes and execution
    // ----------------------------------------
    // Execution and software writes share this process so each register has one driver.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_enable <= 1'b0;
            working <= `RST_BYTE;
            flags <= `RST_BYTE;
            bank_select_register <= `RST_NIBBLE;
            working_shadow <= `RST_BYTE;
            flags_shadow <= `RST_BYTE;
            bank_select_shadow <= `RST_NIBBLE;
            pc <= `RST_PC;
            sp <= `RST_NIBBLE;
            index_base <= `RST_ADDR;
            mem_addr <= `RST_ADDR;
            bad_opcode <= 1'b0;
            stack_fault <= 1'b0;
        end else if (exec) begin
            bad_opcode <= !(ret_op || rot_op);
            if (ret_op) begin
                // A return on an empty stack keeps the pc and raises the fault instead.
                if (sp == 4'h0) begin
                    stack_fault <= 1'b1;
                end else begin
                    pc <= top_of_stack;
                    sp <= sp_m1;
                    stack_fault <= 1'b0;
                end
                if (ret_restore) begin
                    working <= working_shadow;
                    flags <= flags_shadow;
                    bank_select_register <= bank_select_shadow;
                end
            end else if (rot_op) begin
                flags <= next_flags;
                if (!rot_d) begin
                    working <= rotate_left_through_carry;
                end
            end
        end else if (do_write) begin
            case (acc_addr)
                `OFS_CTRL: ext_enable <= hwdata[`CTRL_EXT];
                `OFS_STATUS: begin
                    bad_opcode <= 1'b0;
                    stack_fault <= 1'b0;
                end
                `OFS_WORKING: working <= hwdata[7:0];
                `OFS_FLAGS: flags <= hwdata[7:0];
                `OFS_BANK: bank_select_register <= hwdata[3:0];
                `OFS_WORKING_SH: working_shadow <= hwdata[7:0];
                `OFS_FLAGS_SH: flags_shadow <= hwdata[7:0];
                `OFS_BANK_SH: bank_select_shadow <= hwdata[3:0];
                `OFS_PC: pc <= hwdata[20:0];
                `OFS_STACK: begin
                    // A push onto a full stack is refused and flagged, so no entry is lost.
                    if (stack_full) begin
                        stack_fault <= 1'b1;
                    end else begin
                        sp <= sp + 4'h1;
                    end
                end
                `OFS_INDEX: index_base <= hwdata[11:0];
                `OFS_MEM_ADDR: mem_addr <= hwdata[11:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Stack and file memory storage
    // ----------------------------------------
    // Contents carry no reset; the pointer alone says what is valid.
    always @(posedge hclk) begin
        if (do_write && (acc_addr == `OFS_STACK) && !stack_full) begin
            return_stack[sp[2:0]] <= hwdata[20:0];
        end
    end

    // A rotate that writes back takes the memory port ahead of any software write.
    always @(posedge hclk) begin
        if (exec && rot_op && rot_d) begin
            file_mem[rot_addr] <= rotate_left_through_carry;
        end else if (do_write && (acc_addr == `OFS_MEM_DATA)) begin
            file_mem[mem_addr] <= hwdata[7:0];
        end
    end

endmodule // return_and_rotate_left_exec

//--- logic/rlx_regs.vh
// Constants for the return and rotate-left execution block.
// Assumes a word-addressed AHB-Lite slave decoding haddr[7:2].
`ifndef RLX_REGS_VH
`define RLX_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_INSTR 8'h04
`define OFS_STATUS 8'h08
`define OFS_WORKING 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_BANK 8'h14
`define OFS_WORKING_SH 8'h18
`define OFS_FLAGS_SH 8'h1C
`define OFS_BANK_SH 8'h20
`define OFS_PC 8'h24
`define OFS_STACK 8'h28
`define OFS_INDEX 8'h2C
`define OFS_MEM_ADDR 8'h30
`define OFS_MEM_DATA 8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLAG_CARRY 0
`define FLAG_ZERO 2
`define FLAG_NEG 4
`define CTRL_EXT 0
`define STAT_BAD_OP 8
`define STAT_STACK_FAULT 9

// ----------------------------------------
// Opcode patterns and limits
// ----------------------------------------
`define OP_RETURN 15'h0009
`define OP_ROTATE 6'h0D
`define ACCESS_LIMIT 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define STACK_DEPTH 4'h8
`define RETURN_IDLE_CYCLES 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_PC 21'h00_0000
`define RST_ADDR 12'h000

`endif

//--- bench/rlx_checker_sva.sv
// Checker for the return and rotate execution block.
// Assumes one AHB-Lite master with hready looped back from hreadyout.
`include "rlx_regs.vh"
module rlx_checker (
    // Clock, reset and bus.
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic dp, wr, ok;
    logic [7:0] ofs, wk, wsh;
    logic [3:0] sp;
    wire take = hsel && hready && htrans[1];
    wire ins = dp && wr && ofs == `OFS_INSTR;
    wire ret = ins && hwdata[15:1] == `OP_RETURN;
    wire rot = ins && hwdata[15:10] == `OP_ROTATE;
    // Tracks the working register and stack depth as software should see them.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= 1'b0;
            wr <= 1'b0;
            ok <= 1'b1;
            ofs <= 8'h00;
            wk <= 8'h00;
            wsh <= 8'h00;
            sp <= 4'h0;
        end else begin
            dp <= take;
            if (take) begin
                wr <= hwrite;
                ofs <= {haddr[7:2], 2'b00};
            end
            if (dp && wr && ofs == `OFS_WORKING) begin
                wk <= hwdata[7:0];
                ok <= 1'b1;
            end
            if (dp && wr && ofs == `OFS_WORKING_SH) wsh <= hwdata[7:0];
            if (dp && wr && ofs == `OFS_STACK && sp < `STACK_DEPTH) sp <= sp + 4'h1;
            if (ret && hwdata[0]) wk <= wsh;
            if (ret && sp != 4'h0) sp <= sp - 4'h1;
            if (rot && !hwdata[9]) ok <= 1'b0;
        end
    end
    property p_ret_wait; ret |-> !hreadyout ##1 !hreadyout ##1 hreadyout; endproperty
    a_ret_wait: assert property (p_ret_wait) else $error("return wait wrong");
    property p_ret_idle; ret |=> $stable(hrdata) [*2]; endproperty
    a_ret_idle: assert property (p_ret_idle) else $error("return idle moved");
    property p_take_low; take |=> !hreadyout; endproperty
    a_take_low: assert property (p_take_low) else $error("no wait state");
    property p_sp; dp && !wr && ofs == `OFS_STATUS |=> hrdata[3:0] == sp; endproperty
    a_sp: assert property (p_sp) else $error("stack depth wrong");
    property p_rot_wait; rot |-> !hreadyout ##1 hreadyout; endproperty
    a_rot_wait: assert property (p_rot_wait) else $error("rotate wait wrong");
    property p_rot_okay; rot |-> !hresp ##1 !hresp; endproperty
    a_rot_okay: assert property (p_rot_okay) else $error("rotate not okay");
    property p_work; dp && !wr && ofs == `OFS_WORKING && ok |=> hrdata[7:0] == wk; endproperty
    a_work: assert property (p_work) else $error("working wrong");
    c_ret_sh: cover property (ret && hwdata[0]);
    c_rot_w: cover property (rot && !hwdata[9]);
    c_rot_acc: cover property (rot && !hwdata[8]);
endmodule // rlx_checker

bind return_and_rotate_left_exec rlx_checker u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);

//--- bench/return_and_rotate_left_exec_tb.sv
// Testbench for the return and rotate execution block.
// Assumes hready is looped back from hreadyout and the bench is the only master.
`include "rlx_regs.vh"
module return_and_rotate_left_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    int err_total, n_checks;
    logic [7:0] pre[3] = '{8'h11, 8'h04, 8'h03};
    logic [7:0] sh[3] = '{8'hA5, 8'h13, 8'h07};
    logic [15:0] rop[6] = '{16'h3740, 16'h3610, 16'h3660, 16'h3620, 16'h365F, 16'h3660};
    logic [11:0] rma[6] = '{12'h240, 12'h010, 12'hF60, 12'h120, 12'h15F, 12'hF60};
    logic [7:0] rv[6] = '{8'hE6, 8'h80, 8'h01, 8'h40, 8'h7F, 8'h81};
    logic [7:0] rres[6] = '{8'hCC, 8'h00, 8'h03, 8'h81, 8'hFE, 8'h02};
    logic [7:0] rfl[6] = '{8'h11, 8'h05, 8'h00, 8'h10, 8'h10, 8'h01};
    logic [5:0] rx = 6'b11_1000;
    logic [5:0] rci = 6'b00_1100;

    return_and_rotate_left_exec uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // One single AHB-Lite transfer; read data lands in rdv.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        n_checks++;
        if (rdv !== e) begin
            err_total++;
            $display("mismatch at %0t: read %h expected %h", $time, rdv, e);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        err_total++;
        print_verdict;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 13; i++) if (i != 1) rc(8'(i * 4), 32'h0000_0000);
        rc(8'h3C, 32'h0000_0000);
        $display("test reset values done");
        for (int k = 0; k < 3; k++) begin
            wr(8'(`OFS_WORKING + 4 * k), {24'h00_0000, pre[k]});
            wr(8'(`OFS_WORKING_SH + 4 * k), {24'h00_0000, sh[k]});
        end
        wr(`OFS_STACK, 32'h0001_2345);
        wr(`OFS_STACK, 32'h0000_0ABC);
        wr(`OFS_INSTR, 32'h0000_0012);
        rc(`OFS_PC, 32'h0000_0ABC);
        rc(`OFS_STATUS, 32'h0000_0001);
        for (int k = 0; k < 3; k++) rc(8'(`OFS_WORKING + 4 * k), {24'h00_0000, pre[k]});
        wr(`OFS_INSTR, 32'h0000_0013);
        rc(`OFS_PC, 32'h0001_2345);
        for (int k = 0; k < 3; k++) rc(8'(`OFS_WORKING + 4 * k), {24'h00_0000, sh[k]});
        wr(`OFS_INSTR, 32'h0000_0013);
        rc(`OFS_STATUS, 32'h0000_0200);
        $display("test return done");
        wr(`OFS_STATUS, 32'h0000_0000);
        for (int k = 0; k < 9; k++) wr(`OFS_STACK, 32'h0000_0100 + 32'(k));
        rc(`OFS_STACK, 32'h0000_0107);
        rc(`OFS_STATUS, 32'h0000_0208);
        wr(`OFS_INSTR, 32'h0000_FFFF);
        rc(`OFS_STATUS, 32'h0000_0308);
        wr(`OFS_INSTR, 32'h0000_0012);
        rc(`OFS_PC, 32'h0000_0107);
        rc(`OFS_STATUS, 32'h0000_0007);
        rc(`OFS_STACK, 32'h0000_0106);
        $display("test stack depth and opcode status done");
        wr(`OFS_BANK, 32'h0000_0002);
        wr(`OFS_INDEX, 32'h0000_0100);
        for (int k = 0; k < 6; k++) begin
            wr(`OFS_CTRL, {31'h0000_0000, rx[k]});
            wr(`OFS_FLAGS, {31'h0000_0000, rci[k]});
            wr(`OFS_MEM_ADDR, {20'h0_0000, rma[k]});
            wr(`OFS_MEM_DATA, {24'h00_0000, rv[k]});
            wr(`OFS_INSTR, {16'h0000, rop[k]});
            rc(`OFS_MEM_DATA, {24'h00_0000, rres[k]});
            rc(`OFS_FLAGS, {24'h00_0000, rfl[k]});
        end
        $display("test rotate addressing done");
        wr(`OFS_FLAGS, 32'h0000_0000);
        wr(`OFS_MEM_ADDR, 32'h0000_0240);
        wr(`OFS_INSTR, 32'h0000_3540);
        rc(`OFS_WORKING, 32'h0000_0098);
        rc(`OFS_MEM_DATA, 32'h0000_00CC);
        rc(`OFS_FLAGS, 32'h0000_0011);
        $display("test rotate to working done");
        print_verdict;
    end
endmodule // return_and_rotate_left_exec_tb
